// ==== src/otf_pkg.sv ====
// Purpose: Shared constants for the output terminal function selector.
// Assumes: 20 MHz system clock, five digital output terminals.
// Notes:   Function codes 0 to 18 are handled; others read as no output.
package otf_pkg;

   // -------------------------------------------------------------------
   // Sizes and clock
   // -------------------------------------------------------------------
   localparam int          TERMINALS    = 5;
   localparam int          CODE_W       = 6;
   localparam int          DATA_W       = 32;
   localparam longint      CLK_HZ       = 20000000;

   // -------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------
   localparam longint      PULSE_MS     = 250;
   localparam longint      PULSE_CYCLES = (PULSE_MS * CLK_HZ) / 1000;
   localparam longint      PREWARN_S    = 10;
   localparam longint      MS_CYCLES    = CLK_HZ / 1000;

   // -------------------------------------------------------------------
   // Function codes
   // -------------------------------------------------------------------
   localparam logic [5:0]  FN_NONE      = 6'h00;
   localparam logic [5:0]  FN_RUN       = 6'h01;
   localparam logic [5:0]  FN_FAULT     = 6'h02;
   localparam logic [5:0]  FN_FDT       = 6'h03;
   localparam logic [5:0]  FN_FREACH    = 6'h04;
   localparam logic [5:0]  FN_ZERO      = 6'h05;
   localparam logic [5:0]  FN_MOT_OL    = 6'h06;
   localparam logic [5:0]  FN_DRV_OL    = 6'h07;
   localparam logic [5:0]  FN_SET_CNT   = 6'h08;
   localparam logic [5:0]  FN_DES_CNT   = 6'h09;
   localparam logic [5:0]  FN_LENGTH    = 6'h0a;
   localparam logic [5:0]  FN_CYCLE     = 6'h0b;
   localparam logic [5:0]  FN_RUNTIME   = 6'h0c;
   localparam logic [5:0]  FN_FLIMIT    = 6'h0d;
   localparam logic [5:0]  FN_TLIMIT    = 6'h0e;
   localparam logic [5:0]  FN_READY     = 6'h0f;
   localparam logic [5:0]  FN_AI_CMP    = 6'h10;
   localparam logic [5:0]  FN_UPPER     = 6'h11;
   localparam logic [5:0]  FN_LOWER     = 6'h12;

   // -------------------------------------------------------------------
   // Reset values of the terminal selections
   // -------------------------------------------------------------------
   localparam logic [5:0]  RST_CODE     = 6'h00;

endpackage : otf_pkg

// ==== src/otf_pulse.sv ====
// Purpose: Stretches a one-cycle event into a fixed-width pulse.
// Assumes: Event input is synchronous to the system clock.
// Notes:   A new event during a pulse restarts the full width.
`timescale 1ns/1ps
`default_nettype none
module otf_pulse #(
   parameter int unsigned WIDTH = 5000000
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic event_i,
   output logic      pulse_o
);

   logic [31:0] count;
   logic [31:0] next_count;

   // -------------------------------------------------------------------
   // Down counter holds the pulse high for WIDTH cycles.
   // -------------------------------------------------------------------
   always_comb begin
      next_count = count;
      if (event_i) begin
         next_count = WIDTH;
      end else if (count != 32'h0000_0000) begin
         next_count = count - 32'h0000_0001;
      end
   end

   // Registers the counter.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count <= 32'h0000_0000;
      end else begin
         count <= next_count;
      end
   end

   assign pulse_o = (count != 32'h0000_0000);

endmodule : otf_pulse
`default_nettype wire

// ==== src/otf_prewarn.sv ====
// Purpose: Raises a warning a fixed lead time before overload protection.
// Assumes: Remaining time to protection counts down in milliseconds.
// Notes:   Warning holds while the drive is in overload accumulation.
`timescale 1ns/1ps
`default_nettype none
module otf_prewarn #(
   parameter int unsigned LEAD_MS = 10000
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        active_i,
   input  wire logic [31:0] remain_ms_i,
   output logic             warn_o
);

   logic warn;
   logic next_warn;

   // -------------------------------------------------------------------
   // Warn once the remaining time falls to the lead time or below.
   // -------------------------------------------------------------------
   always_comb begin
      next_warn = active_i && (remain_ms_i <= LEAD_MS);
   end

   // Registers the warning.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         warn <= 1'b0;
      end else begin
         warn <= next_warn;
      end
   end

   assign warn_o = warn;

endmodule : otf_prewarn
`default_nettype wire

// ==== src/otf_select.sv ====
// Purpose: Maps drive status conditions onto five digital output terminals.
// Assumes: All status inputs come from logic on the system clock.
// Notes:   Each terminal has its own function code; outputs are registered.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Five terminals, each with own selection code
// - Code 0 holds terminal OFF
// - Code 1 ON while running, zero included
// - Code 2 ON after fault stop
// - Code 5 ON running at zero frequency
// - Code 6 ON above motor overload threshold
// - Code 7 ON ten seconds before overload
// - Code 8 ON when count reaches set
// - Code 9 ON when count reaches designated
// - Code 10 ON when length exceeds setting
// - Code 11 gives 250 ms cycle pulse
// - Code 12 ON beyond running time threshold
// - Code 13 ON when frequency limited
// - Code 14 ON with torque limit stall
// - Code 15 ON when ready to run
// - Code 16 ON when input one exceeds two
// - Code 17 ON at frequency upper limit
// - Code 18 ON at lower limit, OFF stopped
module otf_select #(
   parameter int unsigned PULSE_CYCLES = 32'(otf_pkg::PULSE_CYCLES),
   parameter int unsigned PREWARN_MS   = 32'(otf_pkg::PREWARN_S * 1000)
) (
   input  wire logic        CLK_SYS_I,
   input  wire logic        RST_N_I,
   // Function selection, one code per terminal.
   input  wire logic [5:0]  SEL_COLLECTOR_TWO_I,
   input  wire logic [5:0]  SEL_RELAY_ONE_I,
   input  wire logic [5:0]  SEL_RELAY_TWO_I,
   input  wire logic [5:0]  SEL_COLLECTOR_ONE_I,
   input  wire logic [5:0]  SEL_COLLECTOR_THREE_I,
   // Drive state.
   input  wire logic        RUNNING_I,
   input  wire logic        FAULT_STOP_I,
   input  wire logic        READY_I,
   input  wire logic        SPEED_MODE_I,
   input  wire logic        TORQUE_AT_LIMIT_I,
   input  wire logic        FREQ_LEVEL_DETECT_ONE_I,
   input  wire logic        FREQ_REACHED_I,
   input  wire logic        CYCLE_DONE_I,
   input  wire logic        DRIVE_OL_ACTIVE_I,
   input  wire logic [31:0] DRIVE_OL_REMAIN_MS_I,
   // Quantities and their thresholds.
   input  wire logic [31:0] OUT_FREQ_I,
   input  wire logic [31:0] SET_FREQ_I,
   input  wire logic [31:0] FREQ_UPPER_I,
   input  wire logic [31:0] FREQ_LOWER_I,
   input  wire logic [31:0] MOTOR_LOAD_I,
   input  wire logic [31:0] MOTOR_OVERLOAD_PARAM_I,
   input  wire logic [31:0] COUNT_VALUE_I,
   input  wire logic [31:0] SET_COUNT_TARGET_I,
   input  wire logic [31:0] DESIGNATED_COUNT_TARGET_I,
   input  wire logic [31:0] ACTUAL_LENGTH_I,
   input  wire logic [31:0] LENGTH_SETTING_I,
   input  wire logic [31:0] RUN_TIME_I,
   input  wire logic [31:0] RUNNING_TIME_THRESHOLD_I,
   input  wire logic [31:0] ANALOG_INPUT_ONE_I,
   input  wire logic [31:0] ANALOG_INPUT_TWO_I,
   // Terminals.
   output logic             COLLECTOR_OUTPUT_TWO_O,
   output logic             RELAY_ONE_O,
   output logic             RELAY_TWO_O,
   output logic             COLLECTOR_OUTPUT_ONE_O,
   output logic             COLLECTOR_OUTPUT_THREE_O,
   output logic             STALL_PROTECT_O
);

   localparam int N = otf_pkg::TERMINALS;

   logic [5:0]   sel [N];
   logic [N-1:0] term;
   logic [N-1:0] next_term;
   logic         stall;
   logic         next_stall;
   logic         cycle_pulse;
   logic         drive_warn;
   logic         freq_limited;
   logic         at_upper;
   logic         at_lower;

   // -------------------------------------------------------------------
   // Terminal selection table
   // -------------------------------------------------------------------

   // Collects the five selections into one indexed table.
   assign sel[0] = SEL_COLLECTOR_TWO_I;
   assign sel[1] = SEL_RELAY_ONE_I;
   assign sel[2] = SEL_RELAY_TWO_I;
   assign sel[3] = SEL_COLLECTOR_ONE_I;
   assign sel[4] = SEL_COLLECTOR_THREE_I;

   // -------------------------------------------------------------------
   // Derived conditions
   // -------------------------------------------------------------------

   // Limit reached means the running frequency sits at or past the limit.
   assign at_upper = RUNNING_I && (OUT_FREQ_I >= FREQ_UPPER_I);
   assign at_lower = RUNNING_I && (OUT_FREQ_I <= FREQ_LOWER_I);

   // Set point outside the limits and output pinned at that limit.
   assign freq_limited = ((SET_FREQ_I > FREQ_UPPER_I) && at_upper) ||
                         ((SET_FREQ_I < FREQ_LOWER_I) && at_lower);

   // Stretches each program cycle completion into one fixed pulse.
   otf_pulse #(
      .WIDTH   (PULSE_CYCLES)
   ) u_cycle_pulse (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (RST_N_I),
      .event_i (CYCLE_DONE_I),
      .pulse_o (cycle_pulse)
   );

   // Warns the lead time ahead of drive overload protection.
   otf_prewarn #(
      .LEAD_MS     (PREWARN_MS)
   ) u_prewarn (
      .clk_i       (CLK_SYS_I),
      .rst_n_i     (RST_N_I),
      .active_i    (DRIVE_OL_ACTIVE_I),
      .remain_ms_i (DRIVE_OL_REMAIN_MS_I),
      .warn_o      (drive_warn)
   );

   // -------------------------------------------------------------------
   // Function decode
   // -------------------------------------------------------------------

   // Returns the condition that a function code selects.
   function automatic logic decode(input logic [5:0] code);
      logic v;
      v = 1'b0;
      case (code)
         otf_pkg::FN_NONE:    v = 1'b0;
         otf_pkg::FN_RUN:     v = RUNNING_I;
         otf_pkg::FN_FAULT:   v = FAULT_STOP_I;
         otf_pkg::FN_FDT:     v = FREQ_LEVEL_DETECT_ONE_I;
         otf_pkg::FN_FREACH:  v = FREQ_REACHED_I;
         otf_pkg::FN_ZERO:
            v = RUNNING_I && (OUT_FREQ_I == 32'h0000_0000);
         otf_pkg::FN_MOT_OL:
            v = MOTOR_LOAD_I > MOTOR_OVERLOAD_PARAM_I;
         otf_pkg::FN_DRV_OL:  v = drive_warn;
         otf_pkg::FN_SET_CNT:
            v = COUNT_VALUE_I >= SET_COUNT_TARGET_I;
         otf_pkg::FN_DES_CNT:
            v = COUNT_VALUE_I >= DESIGNATED_COUNT_TARGET_I;
         otf_pkg::FN_LENGTH:
            v = ACTUAL_LENGTH_I > LENGTH_SETTING_I;
         otf_pkg::FN_CYCLE:   v = cycle_pulse;
         otf_pkg::FN_RUNTIME:
            v = RUN_TIME_I > RUNNING_TIME_THRESHOLD_I;
         otf_pkg::FN_FLIMIT:  v = freq_limited;
         otf_pkg::FN_TLIMIT:  v = stall;
         otf_pkg::FN_READY:   v = READY_I && !FAULT_STOP_I;
         otf_pkg::FN_AI_CMP:
            v = ANALOG_INPUT_ONE_I > ANALOG_INPUT_TWO_I;
         otf_pkg::FN_UPPER:   v = at_upper;
         otf_pkg::FN_LOWER:   v = at_lower;
         default:             v = 1'b0;
      endcase
      return v;
   endfunction : decode

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------

   // Stall protection tracks the torque limit in speed mode; each
   // terminal takes the condition that its code selects.
   always_comb begin
      next_stall = RUNNING_I && SPEED_MODE_I && TORQUE_AT_LIMIT_I;
      for (int i = 0; i < N; i++) begin
         next_term[i] = decode(sel[i]);
      end
   end

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------

   // Holds terminal and stall state; all OFF during reset.
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         term  <= '0;
         stall <= 1'b0;
      end else begin
         term  <= next_term;
         stall <= next_stall;
      end
   end

   // Drives the terminals from their registers.
   assign COLLECTOR_OUTPUT_TWO_O   = term[0];
   assign RELAY_ONE_O              = term[1];
   assign RELAY_TWO_O              = term[2];
   assign COLLECTOR_OUTPUT_ONE_O   = term[3];
   assign COLLECTOR_OUTPUT_THREE_O = term[4];
   assign STALL_PROTECT_O          = stall;

endmodule : otf_select
`default_nettype wire

// ==== testbench/otf_select_props.sv ====
// Purpose: Port-level checks on the terminal function selector.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Level terminals answer one edge after their inputs are sampled.
`timescale 1ns/1ps
`default_nettype none
module otf_select_props #(
   parameter int unsigned PULSE_CYCLES = 20,
   parameter int unsigned PREWARN_MS   = 10
) (
   input  wire logic       CLK_SYS_I,
   input  wire logic       RST_N_I,
   input  wire logic [5:0] SEL_RELAY_ONE_I,
   input  wire logic [5:0] SEL_COLLECTOR_TWO_I,
   input  wire logic       RUNNING_I,
   input  wire logic       FAULT_STOP_I,
   input  wire logic       READY_I,
   input  wire logic       SPEED_MODE_I,
   input  wire logic       TORQUE_AT_LIMIT_I,
   input  wire logic       CYCLE_DONE_I,
   input  wire logic       RELAY_ONE_O,
   input  wire logic       COLLECTOR_OUTPUT_TWO_O,
   input  wire logic       STALL_PROTECT_O
);
   // Every check runs on the system clock and is void while in reset.
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!RST_N_I);

   property p_none; SEL_RELAY_ONE_I == 6'h00 |=> !RELAY_ONE_O; endproperty
   a_none: assert property (p_none) else $error("idle code drove");
   // Attempts start only out of reset, so the held-off first edge after
   // release is not judged against the inputs sampled at it.
   property p_run; RST_N_I && SEL_COLLECTOR_TWO_I == 6'h01 |=>
      COLLECTOR_OUTPUT_TWO_O == $past(RUNNING_I); endproperty
   a_run: assert property (p_run) else $error("run level wrong");
   property p_fault; RST_N_I && SEL_COLLECTOR_TWO_I == 6'h02 |=>
      COLLECTOR_OUTPUT_TWO_O == $past(FAULT_STOP_I); endproperty
   a_fault: assert property (p_fault) else $error("fault wrong");
   property p_ready; RST_N_I && SEL_RELAY_ONE_I == 6'h0f |=>
      RELAY_ONE_O == ($past(READY_I) && !$past(FAULT_STOP_I)); endproperty
   a_ready: assert property (p_ready) else $error("ready wrong");
   property p_refuse; SEL_COLLECTOR_TWO_I > 6'h12 |=>
      !COLLECTOR_OUTPUT_TWO_O; endproperty
   a_refuse: assert property (p_refuse) else $error("bad code on");
   property p_pulse; (RST_N_I && CYCLE_DONE_I &&
      SEL_RELAY_ONE_I == 6'h0b) ##1 (SEL_RELAY_ONE_I == 6'h0b) [*3] |->
      RELAY_ONE_O; endproperty
   a_pulse: assert property (p_pulse) else $error("no pulse");
   property p_stall; RST_N_I && RUNNING_I && SPEED_MODE_I &&
      TORQUE_AT_LIMIT_I |=> STALL_PROTECT_O; endproperty
   a_stall: assert property (p_stall) else $error("no stall");
   property p_nostall; !RUNNING_I |=> !STALL_PROTECT_O; endproperty
   a_nostall: assert property (p_nostall) else $error("stall idle");
endmodule : otf_select_props
`default_nettype wire

// ==== testbench/otf_term_model.sv ====
// Purpose: Equipment on a relay terminal that times each closing.
// Assumes: The terminal is a level on the system clock.
// Notes:   Keeps the length of the last finished ON period.
`timescale 1ns/1ps
`default_nettype none
module otf_term_model (
   input  wire logic clk_i,
   input  wire logic relay_i,
   output var int    on_len_o
);
   int run;
   // Counts closed cycles and latches the count when the contact opens.
   always_ff @(posedge clk_i) begin
      if (relay_i) begin
         run <= run + 1;
      end else begin
         if (run != 0) begin
            on_len_o <= run;
         end
         run <= 0;
      end
   end
endmodule : otf_term_model
`default_nettype wire

// ==== testbench/tb_otf_select.sv ====
// Purpose: Self-checking bench for the terminal function selector.
// Assumes: Short pulse width and prewarn lead to keep the run brief.
// Notes:   All five terminals get the same code in each step.
`timescale 1ns/1ps
`default_nettype none
module tb_otf_select;
   logic clk, rst_n, run, flt, rdy, spd, trq, fdt, frch, cyd, olact, stall;
   logic [31:0] olrem, ofr, sfr, fup, flo, ld, olp, cnt, scnt, dcnt;
   logic [31:0] len, lset, rt, rth, a1, a2;
   logic [5:0]  sel;
   logic [4:0]  t;
   int          err_count, n_checks, plen;

   // Free-running 20 MHz system clock.
   always #25 clk = ~clk;

   otf_select #(.PULSE_CYCLES(20), .PREWARN_MS(10)) otf_select_inst (
      .CLK_SYS_I(clk), .RST_N_I(rst_n), .SEL_COLLECTOR_TWO_I(sel),
      .SEL_RELAY_ONE_I(sel), .SEL_RELAY_TWO_I(sel),
      .SEL_COLLECTOR_ONE_I(sel), .SEL_COLLECTOR_THREE_I(sel),
      .RUNNING_I(run), .FAULT_STOP_I(flt), .READY_I(rdy),
      .SPEED_MODE_I(spd), .TORQUE_AT_LIMIT_I(trq),
      .FREQ_LEVEL_DETECT_ONE_I(fdt), .FREQ_REACHED_I(frch),
      .CYCLE_DONE_I(cyd), .DRIVE_OL_ACTIVE_I(olact),
      .DRIVE_OL_REMAIN_MS_I(olrem), .OUT_FREQ_I(ofr), .SET_FREQ_I(sfr),
      .FREQ_UPPER_I(fup), .FREQ_LOWER_I(flo), .MOTOR_LOAD_I(ld),
      .MOTOR_OVERLOAD_PARAM_I(olp), .COUNT_VALUE_I(cnt),
      .SET_COUNT_TARGET_I(scnt), .DESIGNATED_COUNT_TARGET_I(dcnt),
      .ACTUAL_LENGTH_I(len), .LENGTH_SETTING_I(lset), .RUN_TIME_I(rt),
      .RUNNING_TIME_THRESHOLD_I(rth), .ANALOG_INPUT_ONE_I(a1),
      .ANALOG_INPUT_TWO_I(a2), .COLLECTOR_OUTPUT_TWO_O(t[0]),
      .RELAY_ONE_O(t[1]), .RELAY_TWO_O(t[2]), .COLLECTOR_OUTPUT_ONE_O(t[3]),
      .COLLECTOR_OUTPUT_THREE_O(t[4]), .STALL_PROTECT_O(stall));

   otf_term_model otf_term_model_inst (
      .clk_i(clk), .relay_i(t[1]), .on_len_o(plen));

   // Compares one value and counts the outcome.
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // Selects a code on all terminals and checks them once settled.
   task automatic tc(input logic [5:0] c, input logic e);
      @(posedge clk);
      sel <= c;
      repeat (3) @(posedge clk);
      #1;
      cmp({27'h0, t}, {27'h0, {5{e}}});
   endtask : tc

   // Prints the counts and the verdict, then stops.
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // One program-cycle event gives one pulse of fixed width.
   task automatic t_pulse;
      tc(6'h0b, 1'b0);
      @(posedge clk);
      cyd <= 1'b1;
      @(posedge clk);
      cyd <= 1'b0;
      repeat (30) @(posedge clk);
      #1;
      cmp(plen, 32'd20);
      cmp({27'h0, t}, 32'h0);
   endtask : t_pulse

   // Plain status codes, refused codes and the zero-speed case.
   task automatic t_basic;
      @(posedge clk);
      {run, ofr} <= {1'b1, 32'h0};
      tc(6'h01, 1'b1);
      tc(6'h05, 1'b1);
      tc(6'h00, 1'b0);
      @(posedge clk);
      {flt, rdy, fdt, frch, a1, a2} <= {4'hf, 32'h5, 32'h5};
      tc(6'h3f, 1'b0);
      tc(6'h13, 1'b0);
      tc(6'h02, 1'b1);
      tc(6'h0f, 1'b0);
      tc(6'h03, 1'b1);
      tc(6'h04, 1'b1);
      tc(6'h10, 1'b0);
      @(posedge clk);
      {ofr, flt, a1} <= {32'h1, 1'b0, 32'h6};
      tc(6'h05, 1'b0);
      tc(6'h10, 1'b1);
      tc(6'h0f, 1'b1);
      @(posedge clk);
      {run, ofr} <= {1'b0, 32'h0};
      tc(6'h05, 1'b0);
      tc(6'h01, 1'b0);
   endtask : t_basic

   // Thresholds at and just past their boundaries.
   task automatic t_thresh;
      @(posedge clk);
      {ld, olp, cnt, scnt, dcnt} <= {32'h7, 32'h7, 32'h9, 32'h9, 32'ha};
      {len, lset, rt, rth} <= {32'h4, 32'h4, 32'h3, 32'h3};
      tc(6'h06, 1'b0);
      tc(6'h08, 1'b1);
      tc(6'h09, 1'b0);
      tc(6'h0a, 1'b0);
      tc(6'h0c, 1'b0);
      @(posedge clk);
      {ld, cnt, scnt, len, rt} <= {32'h8, 32'ha, 32'hb, 32'h5, 32'h4};
      tc(6'h06, 1'b1);
      tc(6'h08, 1'b0);
      tc(6'h09, 1'b1);
      tc(6'h0a, 1'b1);
      tc(6'h0c, 1'b1);
   endtask : t_thresh

   // Frequency limits, torque stall and the overload lead warning.
   task automatic t_limits;
      @(posedge clk);
      {run, spd, trq, sfr, fup, flo} <= {3'h7, 32'd120, 32'd100, 32'd10};
      ofr <= 32'd100;
      tc(6'h0d, 1'b1);
      tc(6'h11, 1'b1);
      tc(6'h12, 1'b0);
      tc(6'h0e, 1'b1);
      cmp({31'h0, stall}, 32'h1);
      @(posedge clk);
      {ofr, sfr, spd} <= {32'd10, 32'd5, 1'b0};
      tc(6'h12, 1'b1);
      tc(6'h0d, 1'b1);
      tc(6'h11, 1'b0);
      tc(6'h0e, 1'b0);
      @(posedge clk);
      {run, olact, olrem} <= {2'b01, 32'd11};
      tc(6'h12, 1'b0);
      tc(6'h07, 1'b0);
      @(posedge clk);
      olrem <= 32'd9;
      tc(6'h07, 1'b1);
   endtask : t_limits

   // A reset in mid-run clears the terminals at once.
   task automatic t_reset;
      @(posedge clk);
      run <= 1'b1;
      tc(6'h01, 1'b1);
      @(posedge clk);
      rst_n <= 1'b0;
      #1;
      cmp({27'h0, t}, 32'h0);
      @(posedge clk);
      rst_n <= 1'b1;
      #1;
      cmp({27'h0, t}, 32'h0);
      tc(6'h01, 1'b1);
   endtask : t_reset

   // Main sequence: reset, then every scenario in turn.
   initial begin
      {clk, run, flt, rdy, spd, trq, fdt, frch, cyd, olact, sel} = '0;
      {olrem, ofr, sfr, fup, flo, ld, olp, cnt, scnt, dcnt} = '0;
      {len, lset, rt, rth, a1, a2, err_count, n_checks} = '0;
      rst_n = 1'b0;
      repeat (16) @(posedge clk);
      cmp({27'h0, t}, 32'h0);
      rst_n <= 1'b1;
      t_pulse();
      t_basic();
      t_thresh();
      t_limits();
      t_reset();
      give_verdict();
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      #2000000;
      err_count++;
      give_verdict();
   end
endmodule : tb_otf_select

// Attaches the port checks to every selector instance.
bind otf_select otf_select_props #(
   .PULSE_CYCLES           (PULSE_CYCLES),
   .PREWARN_MS             (PREWARN_MS)
) u_props (
   .CLK_SYS_I              (CLK_SYS_I),
   .RST_N_I                (RST_N_I),
   .SEL_RELAY_ONE_I        (SEL_RELAY_ONE_I),
   .SEL_COLLECTOR_TWO_I    (SEL_COLLECTOR_TWO_I),
   .RUNNING_I              (RUNNING_I),
   .FAULT_STOP_I           (FAULT_STOP_I),
   .READY_I                (READY_I),
   .SPEED_MODE_I           (SPEED_MODE_I),
   .TORQUE_AT_LIMIT_I      (TORQUE_AT_LIMIT_I),
   .CYCLE_DONE_I           (CYCLE_DONE_I),
   .RELAY_ONE_O            (RELAY_ONE_O),
   .COLLECTOR_OUTPUT_TWO_O (COLLECTOR_OUTPUT_TWO_O),
   .STALL_PROTECT_O        (STALL_PROTECT_O)
);
`default_nettype wire
